// File: rtl/snoop_pkg.sv
/*
 * Shared constants and types for the bus snoop controller.
 * Assumes a single bus clock and active-high internal signal levels.
 */
package snoop_pkg;
   // Transfer size codes
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_LINE = 2'h3;
   // Transfer type codes that may be snooped
   localparam logic [1:0] TT_NORMAL = 2'h0;
   localparam logic [1:0] TT_MOVE16 = 2'h1;
   // Snoop control codes
   localparam logic [1:0] SC_INHIBIT = 2'h0;
   localparam logic [1:0] SC_SINK    = 2'h1;
   localparam logic [1:0] SC_INVAL   = 2'h2;
   // Termination classes
   localparam logic [1:0] TERM_NORMAL = 2'h0;
   localparam logic [1:0] TERM_ERROR  = 2'h1;
   localparam logic [1:0] TERM_RETRY  = 2'h2;
   localparam logic [1:0] TERM_BURSTI = 2'h3;
   // Beats of a line, best-case lookup cycles, worst extra cycles
   localparam int         LINE_BEATS    = 4;
   localparam logic [1:0] LAST_BEAT     = 2'h3;
   localparam int         LOOKUP_BASE   = 2;
   localparam int         LOOKUP_EXTRA  = 2;
   localparam logic [1:0] UPA_RESET     = 2'h0;
   // Controller states
   typedef enum logic [2:0] {
      ST_BETWEEN, ST_OWNER, ST_LOOKUP, ST_MEMORY, ST_SUPPLY, ST_SINK
   } snoop_state_t;
endpackage

// File: rtl/snoop_term_count.sv
/*
 * Counts and classifies terminations of an alternate-master cycle.
 * Assumes terminations are only offered while memory inhibit is negated.
 */
`timescale 1ns/1ps
module snoop_term_count (
   input  wire logic       clk,
   input  wire logic       rstN,
   input  wire logic       start,
   input  wire logic       isLine,
   input  wire logic       watch,
   input  wire logic       ackIn,
   input  wire logic       errIn,
   input  wire logic       burstInhIn,
   output logic            done,
   output logic [1:0]      kind
);
   import snoop_pkg::*;

   typedef struct packed {
      logic       busy;   // Counting in progress
      logic [1:0] count;  // Acks seen so far
      logic       line;   // Four acks needed
      logic [1:0] kind;   // Last termination class
   } term_s_t;

   term_s_t    sFf;
   term_s_t    nxt_s;
   logic       lastAck;  // This ack completes the cycle
   logic       active;   // Counting on this edge
   logic       lineNow;  // Line-sized cycle on this edge
   logic [1:0] countNow; // Acks taken before this edge

   // Next-state logic for counting and classifying; the start edge itself
   // already counts, since memory may answer on the first edge after release
   always_comb begin
      nxt_s    = sFf;
      done     = 1'b0;
      active   = start || sFf.busy;
      lineNow  = start ? isLine : sFf.line;
      countNow = start ? 2'h0 : sFf.count;
      lastAck  = !lineNow || (countNow == LAST_BEAT);
      if (start) begin
         nxt_s.busy  = 1'b1;
         nxt_s.count = 2'h0;
         nxt_s.line  = isLine;
      end
      if (active && watch) begin
         if (errIn && ackIn) begin
            nxt_s.kind = TERM_RETRY;
            done       = 1'b1;
         end else if (errIn) begin
            nxt_s.kind = TERM_ERROR;
            done       = 1'b1;
         end else if (ackIn && burstInhIn && lineNow) begin
            nxt_s.kind = TERM_BURSTI;
            done       = 1'b1;
         end else if (ackIn) begin
            nxt_s.count = countNow + 2'h1;
            nxt_s.kind  = TERM_NORMAL;
            done        = lastAck;
         end
         if (done) begin
            nxt_s.busy = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sFf <= '0;
      end else begin
         sFf <= nxt_s;
      end
   end

   assign kind = sFf.kind;
endmodule

// File: rtl/snoop_line_store.sv
/*
 * Small direct-mapped data cache seen by the snooper: tags, per-word dirty
 * bits and line data, with a lookup of fixed latency.
 * Assumes the core fill port and the sink port never hit the same cycle.
 */
`timescale 1ns/1ps
module snoop_line_store #(
   parameter int LINES = 4,
   parameter int EXTRA = 0
) (
   input  wire logic        clk,
   input  wire logic        rstN,
   input  wire logic        lookReq,
   input  wire logic [31:0] lookAddr,
   output logic             lookDone,
   output logic             lookDirty,
   input  wire logic [1:0]  rdWord,
   output logic [31:0]      rdData,
   input  wire logic        sinkEn,
   input  wire logic [1:0]  sinkWord,
   input  wire logic [3:0]  sinkBe,
   input  wire logic [31:0] sinkData,
   input  wire logic        fillEn,
   input  wire logic [31:0] fillAddr,
   input  wire logic [31:0] fillData,
   input  wire logic        fillDirty
);
   import snoop_pkg::*;

   localparam int IW  = $clog2(LINES);
   localparam int LAT = LOOKUP_BASE + EXTRA;

   typedef struct packed {
      logic [LINES-1:0]            valid;
      logic [LINES-1:0][27-IW:0]   tag;
      logic [LINES-1:0][3:0]       dirty;
      logic [LINES-1:0][3:0][31:0] data;
      logic [3:0]                  wait_; // Lookup latency counter
   } store_s_t;

   store_s_t        sFf;
   store_s_t        nxt_s;
   logic [IW-1:0]   lIdx;
   logic [IW-1:0]   fIdx;

   assign lIdx   = lookAddr[4+IW-1:4];
   assign fIdx   = fillAddr[4+IW-1:4];
   assign rdData = sFf.data[lIdx][rdWord];

   // Lookup timing and array updates
   always_comb begin
      nxt_s     = sFf;
      lookDone  = (sFf.wait_ == 4'h1);
      lookDirty = sFf.valid[lIdx] && (sFf.tag[lIdx] == lookAddr[31:4+IW])
                  && (|sFf.dirty[lIdx]);
      if (lookReq) begin
         // Done shows LAT-1 edges after the request, so the release lands
         // two wait states into the access in the best case
         nxt_s.wait_ = 4'(LAT - 1);
      end else if (sFf.wait_ != 4'h0) begin
         nxt_s.wait_ = sFf.wait_ - 4'h1;
      end
      if (sinkEn) begin
         for (int b = 0; b < 4; b++) begin
            if (sinkBe[b]) begin
               nxt_s.data[lIdx][sinkWord][b*8 +: 8] = sinkData[b*8 +: 8];
            end
         end
         nxt_s.dirty[lIdx][sinkWord] = 1'b1;
      end else if (fillEn) begin
         nxt_s.valid[fIdx]                   = 1'b1;
         nxt_s.tag[fIdx]                     = fillAddr[31:4+IW];
         nxt_s.data[fIdx][fillAddr[3:2]]     = fillData;
         nxt_s.dirty[fIdx][fillAddr[3:2]]    = fillDirty;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sFf <= '0;
      end else begin
         sFf <= nxt_s;
      end
   end
endmodule

// File: rtl/bus_snoop_controller.sv
/*
 * Bus snoop controller: watches alternate-master transfers, drives memory
 * inhibit, intervenes on dirty hits and passes page attributes out.
 * Assumes all bus inputs are synchronous to clk and active high.
 */
`timescale 1ns/1ps
module bus_snoop_controller #(
   parameter int LINES = 4,
   parameter int EXTRA = 0
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        busOwned,
   input  wire logic        ownStartReq,
   input  wire logic        ownLastAck,
   input  wire logic [1:0]  pageAttr,
   input  wire logic        transferStart,
   input  wire logic [31:0] address,
   input  wire logic [1:0]  transferSize,
   input  wire logic [1:0]  transferType,
   input  wire logic [2:0]  transferModifier,
   input  wire logic        readWriteSel,
   input  wire logic [1:0]  snoopControl,
   input  wire logic        transferAck,
   input  wire logic        transferErrorAck,
   input  wire logic        transferBurstInhibit,
   input  wire logic [31:0] dataIn,
   input  wire logic        fillEn,
   input  wire logic [31:0] fillAddr,
   input  wire logic [31:0] fillData,
   input  wire logic        fillDirty,
   output logic             memoryInhibit,
   output logic             ackOut,
   output logic             ackOutEn,
   output logic [31:0]      dataOut,
   output logic             dataOutEn,
   output logic [1:0]       userPageAttribute,
   output logic [1:0]       termKind,
   output logic [2:0]       capModifier
);
   import snoop_pkg::*;

   // Snoopable sizes and types
   function automatic logic snoopable(input logic [1:0] tt, input logic [1:0] sz);
      logic sizeOk;
      sizeOk = (sz == SIZE_BYTE) || (sz == SIZE_WORD) || (sz == SIZE_LONG) || (sz == SIZE_LINE);
      return sizeOk && ((tt == TT_NORMAL) || (tt == TT_MOVE16));
   endfunction

   // Byte lanes of a transfer
   function automatic logic [3:0] laneMask(input logic [1:0] sz, input logic [1:0] off);
      logic [3:0] m;
      m = 4'hf;
      if (sz == SIZE_BYTE) begin
         m = 4'(4'h1 << off);
      end else if (sz == SIZE_WORD) begin
         m = off[1] ? 4'hc : 4'h3;
      end
      return m;
   endfunction

   typedef struct packed {
      snoop_state_t st;       // Controller state
      logic         mi;       // Memory inhibit
      logic [31:0]  addr;     // Captured address
      logic [1:0]   siz;      // Captured size
      logic [2:0]   tm;       // Captured modifier
      logic         rd;       // Captured direction, high for read
      logic [1:0]   sc;       // Captured snoop control
      logic [1:0]   beat;     // Intervention beat
      logic         ack;      // Slave acknowledge
      logic         dEn;      // Data drive enable
      logic [31:0]  dOut;     // Slave read data
      logic [1:0]   upa;      // Page attribute out
      logic         lookReq;  // Lookup start pulse
      logic         termGo;   // Termination counter start
   } ctrl_s_t;

   logic [1:0]  syncFf;    // Reset release synchroniser
   logic        rstN;      // Synchronised reset
   ctrl_s_t     sFf;       // State register
   ctrl_s_t     nxt_s;     // Next state
   logic        capture;   // Alternate start seen
   logic        lookDone;  // Lookup finished
   logic        lookDirty; // Line hit and dirty
   logic [31:0] rdData;    // Word for supply
   logic [1:0]  rdWord;    // Word index for supply
   logic        sinkEn;    // Sink write strobe
   logic        termDone;  // Memory termination finished
   logic [1:0]  kindW;     // Termination class
   logic        lastBeat;  // Final intervention beat

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syncFf <= 2'h0;
      end else begin
         syncFf <= {syncFf[0], 1'b1};
      end
   end
   assign rstN = syncFf[1];

   assign capture  = transferStart && !busOwned && (sFf.st == ST_BETWEEN);
   assign lastBeat = (sFf.siz != SIZE_LINE) || (sFf.beat == LAST_BEAT);
   assign rdWord   = sFf.addr[3:2] + sFf.beat + (sFf.ack ? 2'h1 : 2'h0);
   assign sinkEn   = (sFf.st == ST_SINK) && sFf.ack;

   // Cache arrays and lookup
   snoop_line_store #(.LINES(LINES), .EXTRA(EXTRA)) u_store (
      .clk      (clk),
      .rstN     (rstN),
      .lookReq  (sFf.lookReq),
      .lookAddr (sFf.addr),
      .lookDone (lookDone),
      .lookDirty(lookDirty),
      .rdWord   (rdWord),
      .rdData   (rdData),
      .sinkEn   (sinkEn),
      .sinkWord (sFf.addr[3:2] + sFf.beat),
      .sinkBe   (laneMask(sFf.siz, sFf.addr[1:0])),
      .sinkData (dataIn),
      .fillEn   (fillEn),
      .fillAddr (fillAddr),
      .fillData (fillData),
      .fillDirty(fillDirty)
   );

   // Termination counting; blind while inhibit is asserted
   snoop_term_count u_term (
      .clk       (clk),
      .rstN      (rstN),
      .start     (sFf.termGo),
      .isLine    (sFf.siz == SIZE_LINE),
      .watch     (!sFf.mi),
      .ackIn     (transferAck),
      .errIn     (transferErrorAck),
      .burstInhIn(transferBurstInhibit),
      .done      (termDone),
      .kind      (kindW)
   );

   // Controller next state
   always_comb begin
      nxt_s         = sFf;
      nxt_s.lookReq = 1'b0;
      nxt_s.termGo  = 1'b0;
      nxt_s.upa     = busOwned ? pageAttr : UPA_RESET;
      case (sFf.st)
         ST_BETWEEN: begin
            nxt_s.mi = 1'b1;
            if (ownStartReq && busOwned) begin
               nxt_s.mi = 1'b0;
               nxt_s.st = ST_OWNER;
            end else if (capture) begin
               nxt_s.addr = address;
               nxt_s.siz  = transferSize;
               nxt_s.tm   = transferModifier;
               nxt_s.rd   = readWriteSel;
               nxt_s.sc   = snoopControl;
               nxt_s.beat = 2'h0;
               if (snoopable(transferType, transferSize) &&
                   (snoopControl == SC_SINK || snoopControl == SC_INVAL)) begin
                  nxt_s.lookReq = 1'b1;
                  nxt_s.st      = ST_LOOKUP;
               end else begin
                  nxt_s.mi     = 1'b0;
                  nxt_s.termGo = 1'b1;
                  nxt_s.st     = ST_MEMORY;
               end
            end
         end
         ST_OWNER: begin
            nxt_s.mi = 1'b0;
            if (ownLastAck && !busOwned) begin
               nxt_s.mi = 1'b1;
               nxt_s.st = ST_BETWEEN;
            end
         end
         ST_LOOKUP: begin
            nxt_s.mi = 1'b1;
            if (lookDone) begin
               if (lookDirty && sFf.rd) begin
                  nxt_s.st  = ST_SUPPLY;
                  nxt_s.ack = 1'b1;
                  nxt_s.dEn = 1'b1;
                  nxt_s.dOut = rdData;
               end else if (lookDirty && sFf.sc == SC_SINK) begin
                  nxt_s.st  = ST_SINK;
                  nxt_s.ack = 1'b1;
               end else begin
                  nxt_s.mi     = 1'b0;
                  nxt_s.termGo = 1'b1;
                  nxt_s.st     = ST_MEMORY;
               end
            end
         end
         ST_MEMORY: begin
            nxt_s.mi = 1'b0;
            if (termDone) begin
               if (busOwned && ownStartReq) begin
                  nxt_s.st = ST_OWNER;
               end else begin
                  nxt_s.mi = 1'b1;
                  nxt_s.st = ST_BETWEEN;
               end
            end
         end
         ST_SUPPLY, ST_SINK: begin
            nxt_s.mi = 1'b1;
            if (lastBeat) begin
               nxt_s.ack = 1'b0;
               nxt_s.dEn = 1'b0;
               nxt_s.st  = ST_BETWEEN;
            end else begin
               nxt_s.beat = sFf.beat + 2'h1;
               nxt_s.dOut = rdData;
            end
         end
         default: begin
            nxt_s.st = ST_BETWEEN;
            nxt_s.mi = 1'b1;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sFf    <= '0;
         sFf.st <= ST_BETWEEN;
         sFf.mi <= 1'b1;
      end else begin
         sFf <= nxt_s;
      end
   end

   assign memoryInhibit     = sFf.mi;
   assign ackOut            = sFf.ack;
   assign ackOutEn          = sFf.ack;
   assign dataOut           = sFf.dOut;
   assign dataOutEn         = sFf.dEn;
   assign userPageAttribute = sFf.upa;
   assign capModifier       = sFf.tm;
   assign termKind          = kindW;

   // Checks
   sequence seqSnoopStart;
      capture && snoopable(transferType, transferSize) && (snoopControl != SC_INHIBIT)
         && (snoopControl != 2'h3);
   endsequence
   sequence seqLineSupply;
      $rose(sFf.st == ST_SUPPLY) && (sFf.siz == SIZE_LINE);
   endsequence

   a_between_hold: assert property (@(posedge clk) disable iff (!rstN)
      (sFf.st == ST_BETWEEN && !ownStartReq && !capture) |=> memoryInhibit)
      else $error("inhibit dropped between cycles");
   a_reset_hold: assert property (@(posedge clk) disable iff (!rstN)
      $rose(rstN) |-> memoryInhibit)
      else $error("inhibit low after reset");
   a_inhibit_release: assert property (@(posedge clk) disable iff (!rstN)
      (capture && snoopControl == SC_INHIBIT && !ownStartReq) |=> !memoryInhibit && sFf.st == ST_MEMORY)
      else $error("inhibited snoop kept inhibit");
   a_lookup_hold: assert property (@(posedge clk) disable iff (!rstN)
      seqSnoopStart and !ownStartReq |=> memoryInhibit [*2])
      else $error("inhibit dropped during lookup");
   a_release_bound: assert property (@(posedge clk) disable iff (!rstN)
      seqSnoopStart and !ownStartReq |-> ##[3:6] (sFf.st != ST_LOOKUP))
      else $error("lookup outran its bound");
   a_ignore_ack: assert property (@(posedge clk) disable iff (!rstN)
      memoryInhibit |-> !termDone)
      else $error("termination taken under inhibit");
   a_line_beats: assert property (@(posedge clk) disable iff (!rstN)
      seqLineSupply |-> ackOut [*4] ##1 !ackOut)
      else $error("line supply not four beats");
   a_own_start: assert property (@(posedge clk) disable iff (!rstN)
      (sFf.st == ST_BETWEEN && ownStartReq && busOwned) |=> !memoryInhibit)
      else $error("inhibit kept at own start");
   a_lose_bus: assert property (@(posedge clk) disable iff (!rstN)
      (sFf.st == ST_OWNER && ownLastAck && !busOwned) |=> memoryInhibit)
      else $error("inhibit late after losing bus");
   a_capture_size: assert property (@(posedge clk) disable iff (!rstN)
      capture && !ownStartReq |=> sFf.siz == $past(transferSize) && sFf.rd == $past(readWriteSel))
      else $error("capture mismatch");
   a_sink_mark: assert property (@(posedge clk) disable iff (!rstN)
      sinkEn |-> memoryInhibit && !sFf.rd)
      else $error("sink without inhibit");
endmodule

// File: test/snoop_mem_model.sv
/*
 * Memory responder on the far side of the snooper: ends alternate-master
 * cycles with normal, error, retry or burst-inhibited terminations.
 * Assumes the bench arms it per cycle and that clk is the bus clock.
 */
`timescale 1ns/1ps
module snoop_mem_model (
   input  wire logic       clk,
   input  wire logic       memoryInhibit,
   input  wire logic       req,
   input  wire logic [2:0] beats,
   input  wire logic [1:0] kind,
   input  wire logic       slow,
   output logic            transferAck,
   output logic            transferErrorAck,
   output logic            transferBurstInhibit
);
   logic [2:0] sent;   // Terminations offered so far
   logic       gap;    // Wait state toggle for slow answers

   initial begin
      transferAck = 1'b0;
      transferErrorAck = 1'b0;
      transferBurstInhibit = 1'b0;
      sent = 3'h0;
      gap = 1'b0;
   end

   // Drive off the sampling edge; terminate only while inhibit is negated
   always @(negedge clk) begin
      transferAck = 1'b0;
      transferErrorAck = 1'b0;
      transferBurstInhibit = 1'b0;
      gap = slow & ~gap;
      if (!req) begin
         sent = 3'h0;
      end else if (!memoryInhibit && sent < beats && !gap) begin
         transferAck = (kind != 2'h1);
         transferErrorAck = (kind == 2'h1) || (kind == 2'h2);
         transferBurstInhibit = (kind == 2'h3);
         sent = sent + 3'h1;
      end
   end
endmodule

// File: test/bus_snoop_controller_tb.sv
/*
 * Self-checking bench for the bus snoop controller.
 * Assumes the memory responder model and the snoop package are compiled first.
 */
`timescale 1ns/1ps
module bus_snoop_controller_tb;
   import snoop_pkg::*;
   logic clk, arst_n, busOwned, ownStartReq, ownLastAck, transferStart, readWriteSel;
   logic [1:0] pageAttr, transferSize, transferType, snoopControl, kind, userPageAttribute, termKind;
   logic [2:0] transferModifier, beats, capModifier;
   logic [31:0] address, dataIn, fillAddr, fillData, dataOut;
   logic transferAck, transferErrorAck, transferBurstInhibit, fillEn, fillDirty, req, slow;
   logic memoryInhibit, ackOut, ackOutEn, dataOutEn;
   int n_fail, checked;

   bus_snoop_controller #(.LINES(4), .EXTRA(0)) u_bus_snoop_controller (
      .clk(clk), .arst_n(arst_n), .busOwned(busOwned), .ownStartReq(ownStartReq), .ownLastAck(ownLastAck),
      .pageAttr(pageAttr), .transferStart(transferStart), .address(address), .transferSize(transferSize),
      .transferType(transferType), .transferModifier(transferModifier), .readWriteSel(readWriteSel),
      .snoopControl(snoopControl), .transferAck(transferAck), .transferErrorAck(transferErrorAck),
      .transferBurstInhibit(transferBurstInhibit), .dataIn(dataIn), .fillEn(fillEn), .fillAddr(fillAddr),
      .fillData(fillData), .fillDirty(fillDirty), .memoryInhibit(memoryInhibit), .ackOut(ackOut),
      .ackOutEn(ackOutEn), .dataOut(dataOut), .dataOutEn(dataOutEn), .userPageAttribute(userPageAttribute),
      .termKind(termKind), .capModifier(capModifier));

   snoop_mem_model u_snoop_mem_model (
      .clk(clk), .memoryInhibit(memoryInhibit), .req(req), .beats(beats), .kind(kind), .slow(slow),
      .transferAck(transferAck), .transferErrorAck(transferErrorAck),
      .transferBurstInhibit(transferBurstInhibit));

   // 20 MHz bus clock
   always #25 clk = ~clk;

   // Compare one result and count it
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Offer one alternate-master start; returns just after the taken edge
   task automatic start(input logic [1:0] sz, tt, sc, input logic rw, input logic [31:0] a);
      @(negedge clk);
      transferStart = 1'b1;
      transferSize = sz;
      transferType = tt;
      snoopControl = sc;
      readWriteSel = rw;
      address = a;
      transferModifier = a[6:4];
      @(negedge clk);
      transferStart = 1'b0;
      cmp(32'(capModifier), 32'(a[6:4]));
   endtask

   // Edges from the taken edge until inhibit is negated
   task automatic wait_low(output int n);
      n = 1;
      while (memoryInhibit !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
   endtask

   // Let memory end the cycle and judge the count of acks and the class
   task automatic mem_end(input logic [2:0] b, input logic [1:0] k, input int expAcks);
      int nAck;
      nAck = 0;
      beats = b;
      kind = k;
      req = 1'b1;
      repeat (40) begin
         @(posedge clk);
         if (transferAck)
            nAck++;
         @(negedge clk);
         if (memoryInhibit)
            break;
      end
      req = 1'b0;
      cmp(32'(nAck), 32'(expAcks));
      cmp(32'(termKind), 32'(k));
      cmp(32'(memoryInhibit), 32'h1);
   endtask

   task automatic t_reset;
      cmp(32'(memoryInhibit), 32'h1);
      cmp(32'({ackOut, ackOutEn, dataOutEn}), 32'h0);
   endtask

   // Inhibited snoop on every size: released at once, line still needs four acks
   task automatic t_inhibited;
      int n;
      for (int s = 0; s < 4; s++) begin
         start(2'(s), TT_NORMAL, SC_INHIBIT, 1'b1, 32'h40 + 32'(s) * 32'h10);
         wait_low(n);
         cmp(32'(n <= 1), 32'h1);
         slow = (s == 3);
         mem_end((s == 3) ? 3'h4 : 3'h1, TERM_NORMAL, (s == 3) ? 4 : 1);
         slow = 1'b0;
      end
   endtask

   // Clean lookup: inhibit held for the lookup then released
   task automatic t_clean;
      int n;
      start(SIZE_LONG, TT_MOVE16, SC_INVAL, 1'b1, 32'h200);
      wait_low(n);
      cmp(32'(n), 32'(LOOKUP_BASE + 1));
      mem_end(3'h1, TERM_NORMAL, 1);
   endtask

   // Unsnooped line ended by error, retry and burst inhibit; type two never snooped
   task automatic t_unsnooped;
      int n;
      start(SIZE_LINE, 2'h2, SC_SINK, 1'b1, 32'h100);
      wait_low(n);
      cmp(32'(n <= 1), 32'h1);
      mem_end(3'h1, TERM_ERROR, 0);
      start(SIZE_LINE, TT_NORMAL, 2'h3, 1'b0, 32'h100);
      wait_low(n);
      mem_end(3'h1, TERM_RETRY, 1);
      start(SIZE_LINE, TT_NORMAL, 2'h3, 1'b1, 32'h100);
      wait_low(n);
      mem_end(3'h1, TERM_BURSTI, 1);
   endtask

   // Dirty read: device answers as slave with nb words, four for a line
   task automatic t_intervene(input logic [1:0] sz, input logic [31:0] a, input int nb, input logic [31:0] w0);
      int n;
      start(sz, TT_NORMAL, SC_SINK, 1'b1, a);
      n = 0;
      while (ackOut !== 1'b1 && n < 10) begin
         cmp(32'(memoryInhibit), 32'h1);
         @(negedge clk);
         n++;
      end
      cmp(32'(n <= LOOKUP_BASE + LOOKUP_EXTRA), 32'h1);
      n = 0;
      while (ackOut === 1'b1 && n < 8) begin
         cmp({ackOutEn, dataOutEn, memoryInhibit}, 32'h7);
         cmp(dataOut, (n == 0) ? w0 : 32'ha0000000 + 32'(n));
         @(negedge clk);
         n++;
      end
      cmp(32'(n), 32'(nb));
      cmp(32'(memoryInhibit), 32'h1);
   endtask

   // Sink write into a dirty line, then read the word back
   task automatic t_sink;
      int n;
      dataIn = 32'hcafe0001;
      start(SIZE_LONG, TT_NORMAL, SC_SINK, 1'b0, 32'h104);
      n = 0;
      repeat (10) begin
         if (ackOut === 1'b1)
            n++;
         @(negedge clk);
      end
      cmp(32'(n), 32'h1);
      t_intervene(SIZE_LONG, 32'h104, 1, 32'hcafe0001);
   endtask

   // Own cycles: inhibit follows own start and final ack, attributes pass out
   task automatic t_own;
      @(negedge clk);
      busOwned = 1'b1;
      pageAttr = 2'h2;
      ownStartReq = 1'b1;
      @(negedge clk);
      ownStartReq = 1'b0;
      cmp(32'(memoryInhibit), 32'h0);
      @(negedge clk);
      cmp(32'(userPageAttribute), 32'h2);
      busOwned = 1'b0;
      ownLastAck = 1'b1;
      @(negedge clk);
      ownLastAck = 1'b0;
      cmp(32'(memoryInhibit), 32'h1);
      cmp(32'(userPageAttribute), 32'h0);
   endtask

   initial begin
      {clk, arst_n, busOwned, ownStartReq, ownLastAck, transferStart, readWriteSel} = '0;
      {pageAttr, transferSize, transferType, snoopControl, kind, transferModifier, beats} = '0;
      {address, dataIn, fillAddr, fillData, fillEn, fillDirty, req, slow} = '0;
      n_fail = 0;
      checked = 0;
      repeat (8) @(negedge clk);
      t_reset();
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_reset();
      t_inhibited();
      t_clean();
      t_unsnooped();
      // Core fills a dirty line at 0x100
      for (int i = 0; i < 4; i++) begin
         fillEn = 1'b1;
         fillDirty = 1'b1;
         fillAddr = 32'h100 + 32'(i) * 32'h4;
         fillData = 32'ha0000000 + 32'(i);
         @(negedge clk);
      end
      fillEn = 1'b0;
      t_intervene(SIZE_LINE, 32'h100, LINE_BEATS, 32'ha0000000);
      t_sink();
      t_own();
      tally_and_finish();
   end

   // Watchdog far beyond the expected run of about a hundred cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
endmodule
